// ===== rtl/psbc_pkg.sv
package psbc_pkg;

  // Geometry of the wide variant; the narrow variant uses two lanes.
  localparam int PSBC_LANES       = 4;
  localparam int PSBC_ADDR_W      = 19;
  localparam int PSBC_BYTE_W      = 8;
  localparam int PSBC_LANE_W      = 9;
  localparam int PSBC_BURST_W     = 2;
  localparam int PSBC_BUF_DEPTH   = 2;
  localparam int PSBC_SYNC_STAGES = 2;

  // Burst order input levels.
  localparam logic PSBC_ORDER_LINEAR = 1'b0;

  // Reset values of the pipeline.
  localparam logic [1:0] PSBC_CNT_RST = 2'h0;

  // Operation held by each pipeline stage.
  typedef enum logic [1:0] {PSBC_OP_DESEL, PSBC_OP_READ, PSBC_OP_WRITE} psbc_op_t;

  // Low address bits of the given burst step, linear or interleaved.
  function automatic logic [1:0] psbc_burst_low(input logic order, input logic [1:0] start,
                                                input logic [1:0] step);
    logic [1:0] sum;
    sum = 2'(start + step);
    return (order == PSBC_ORDER_LINEAR) ? sum : (start ^ step);
  endfunction

endpackage

// ===== rtl/psbc_mem.sv
`timescale 1ns/1ns
`default_nettype none
module psbc_mem
  import psbc_pkg::*;
#(
  parameter int ADDR_W = PSBC_ADDR_W,
  parameter int LANES  = PSBC_LANES,
  parameter int LANE_W = PSBC_LANE_W
)(
  // Clock.
  input  wire logic                    ref_clk,
  // Write port with one enable per lane.
  input  wire logic                    wr_en,
  input  wire logic [ADDR_W-1:0]       wr_addr,
  input  wire logic [LANES-1:0]        wr_lanes,
  input  wire logic [LANES*LANE_W-1:0] wr_data,
  // Registered read port.
  input  wire logic                    rd_en,
  input  wire logic [ADDR_W-1:0]       rd_addr,
  output var  logic [LANES*LANE_W-1:0] rd_data
);

  logic [LANES*LANE_W-1:0] mem_array [0:(1<<ADDR_W)-1];

  // Only lanes whose enable is set are written; the others keep their contents.
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < LANES; i++)
    begin
      if (wr_en && wr_lanes[i])
      begin
        mem_array[wr_addr][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
      end
    end
    if (rd_en)
    begin
      rd_data <= mem_array[rd_addr];
    end
  end

endmodule
`default_nettype wire

// ===== rtl/psbc_buf.sv
`timescale 1ns/1ns
`default_nettype none
module psbc_buf
  import psbc_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = PSBC_BUF_DEPTH
)(
  // Clock and reset.
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // Filling side.
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  wire              push;
  wire              pop;

  assign in_ready  = (count_reg != CNT_W'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = store[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    return (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
  endfunction

  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      store[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= bump(wr_ptr_reg);
      end
      if (pop)
      begin
        rd_ptr_reg <= bump(rd_ptr_reg);
      end
      if (push && !pop)
      begin
        count_reg <= CNT_W'(count_reg + 1'b1);
      end
      else if (pop && !push)
      begin
        count_reg <= CNT_W'(count_reg - 1'b1);
      end
    end
  end

endmodule
`default_nettype wire

// ===== rtl/psbc_sram.sv
// What this block does
// R1: Deselected at a qualified load edge gives a deselect cycle; advance continues it; bus floats.
// R2: Selected load with write strobe high starts a read burst at the supplied address.
// R3: Advance after a read reads the next burst address, ignoring selects and strobe.
// R4: A read begun with output enable inactive is a dummy read with floating bus.
// R5: A read continuation with output enable inactive advances as a dummy read, floating.
// R6: Selected load, write strobe low, some lane select low starts a write burst.
// R7: Advance after a write with some lane select low writes the next burst address.
// R8: A write begun with all lane selects high is aborted; nothing stored, bus floats.
// R9: A write continuation with all lane selects high advances without changing bytes.
// R10: A high clock qualifier makes the edge ignored; pipeline and read outputs hold, held writes still drain and the sleep synchroniser still shifts.
// R11: Every recognised write cycle floats all data and parity lines.
// R12: After reset the device is deselected with data and parity lines floating.
// R13: Output enable acts without the clock, is masked in writes, gates read data.
// R14: Each low lane select writes its own byte and parity bit; others unchanged.
// R15: High write strobe means read whatever the lane selects; all high writes nothing.
// R16: Sleep input overrides everything, floats bus, two cycles entry and exit, keeps data.
// R17: Burst counter steps two low address bits, wraps; order input picks linear or interleaved.
// R18: The controller presents write data and lane selects on the second qualified edge.
// R19: Read data drive the bus after the second qualified edge following the address edge.
// R20: The controller keeps selects inactive two cycles after sleep ends, deselects before.
`timescale 1ns/1ns
`default_nettype none
module psbc_sram
  import psbc_pkg::*;
#(
  parameter int ADDR_W = PSBC_ADDR_W,
  parameter int LANES  = PSBC_LANES
)(
  // Clock and reset.
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  // Command pins.
  input  wire logic [ADDR_W-1:0]         address,
  input  wire logic                      chip_select_1_n,
  input  wire logic                      chip_select_2,
  input  wire logic                      chip_select_3_n,
  input  wire logic                      advance_or_load,
  input  wire logic                      write_enable_n,
  input  wire logic [LANES-1:0]          byte_lane_select_n,
  input  wire logic                      clock_qualifier_n,
  input  wire logic                      burst_order,
  // Asynchronous pins.
  input  wire logic                      output_enable_n,
  input  wire logic                      sleep_request,
  // Data lanes.
  input  wire logic [LANES*PSBC_BYTE_W-1:0] dq_in,
  output var  logic [LANES*PSBC_BYTE_W-1:0] dq_out,
  output var  logic                      dq_oe,
  // Parity lanes.
  input  wire logic [LANES-1:0]          parity_lane_in,
  output var  logic [LANES-1:0]          parity_lane_out,
  output var  logic                      parity_lane_oe
);

  localparam int WORD_W = LANES * PSBC_LANE_W;
  localparam int BUF_W  = ADDR_W + LANES + WORD_W;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // Sleep synchroniser; its second stage is the sleep state itself.
  logic [PSBC_SYNC_STAGES-1:0] sleep_sync_reg;
  wire                         sleep_active;

  // Command stage and data stage of the pipeline.
  psbc_op_t                    s1_op_reg;
  psbc_op_t                    s1_op_next;
  logic [ADDR_W-1:0]           s1_addr_reg;
  logic [ADDR_W-1:0]           s1_addr_next;
  logic [1:0]                  burst_base_reg;
  logic [1:0]                  burst_base_next;
  logic [1:0]                  burst_cnt_reg;
  logic [1:0]                  burst_cnt_next;
  logic                        s1_abort_reg;
  logic                        s1_abort_next;
  psbc_op_t                    s2_op_reg;
  logic [ADDR_W-1:0]           s2_addr_reg;
  logic                        s2_abort_reg;

  // Read output stage.
  logic                        rd_valid_reg;
  logic [LANES*PSBC_BYTE_W-1:0] dq_out_reg;
  logic [LANES-1:0]            parity_out_reg;

  // Decoded command.
  wire                         qual;
  wire                         all_sel;
  wire                         cmd_load;
  wire                         begin_read;
  wire                         begin_write;
  wire                         lanes_off;
  wire                         adv_cont;
  wire  [1:0]                  step_cnt;
  wire  [1:0]                  step_low;

  // Write path and memory.
  wire  [LANES-1:0]            wr_mask;
  wire  [WORD_W-1:0]           wr_word;
  wire                         buf_in_valid;
  wire                         buf_in_ready;
  wire                         push;
  wire                         buf_out_valid;
  wire  [BUF_W-1:0]            buf_out_data;
  wire                         mem_wr_en;
  wire                         mem_rd_en;
  wire  [WORD_W-1:0]           mem_rdata;
  wire  [LANES*PSBC_BYTE_W-1:0] rd_bytes;
  wire  [LANES-1:0]            rd_parity;

  // Sleep is caught through two flip-flops, which gives the two cycle entry and exit.
  assign sleep_active = sleep_sync_reg[PSBC_SYNC_STAGES-1]; // R16

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sleep_sync_reg <= '0;
    end
    else
    begin
      sleep_sync_reg <= {sleep_sync_reg[PSBC_SYNC_STAGES-2:0], sleep_request}; // R16
    end
  end

  // An edge counts only while the qualifier is low and the device is awake.
  assign qual        = !clock_qualifier_n && !sleep_active; // R10 R16
  assign all_sel     = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
  assign cmd_load    = qual && !advance_or_load;
  assign begin_read  = cmd_load && all_sel && write_enable_n; // R2 R15
  assign begin_write = cmd_load && all_sel && !write_enable_n; // R6
  assign lanes_off   = &byte_lane_select_n;
  assign adv_cont    = qual && advance_or_load && (s1_op_reg != PSBC_OP_DESEL); // R3 R7
  assign step_cnt    = 2'(burst_cnt_reg + 2'h1); // R17
  assign step_low    = psbc_burst_low(burst_order, burst_base_reg, step_cnt); // R17

  // Next command stage; a stalled edge keeps everything.
  always_comb
  begin
    s1_op_next      = s1_op_reg;
    s1_addr_next    = s1_addr_reg;
    burst_base_next = burst_base_reg;
    burst_cnt_next  = burst_cnt_reg;
    s1_abort_next   = s1_abort_reg;
    if (cmd_load)
    begin
      s1_op_next      = begin_read ? PSBC_OP_READ : (begin_write ? PSBC_OP_WRITE : PSBC_OP_DESEL); // R1
      s1_addr_next    = address;
      burst_base_next = address[1:0];
      burst_cnt_next  = PSBC_CNT_RST;
      s1_abort_next   = begin_write && lanes_off; // R8
    end
    else if (adv_cont)
    begin
      s1_addr_next   = {s1_addr_reg[ADDR_W-1:PSBC_BURST_W], step_low}; // R3 R5 R7 R9
      burst_cnt_next = step_cnt;
      s1_abort_next  = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_op_reg      <= PSBC_OP_DESEL; // R12
      s1_addr_reg    <= '0;
      burst_base_reg <= PSBC_CNT_RST;
      burst_cnt_reg  <= PSBC_CNT_RST;
      s1_abort_reg   <= 1'b0;
      s2_op_reg      <= PSBC_OP_DESEL; // R12
      s2_addr_reg    <= '0;
      s2_abort_reg   <= 1'b0;
    end
    else if (sleep_active)
    begin
      s1_op_reg <= PSBC_OP_DESEL; // R16
      s2_op_reg <= PSBC_OP_DESEL; // R16
    end
    else if (qual)
    begin
      s1_op_reg      <= s1_op_next;
      s1_addr_reg    <= s1_addr_next;
      burst_base_reg <= burst_base_next;
      burst_cnt_reg  <= burst_cnt_next;
      s1_abort_reg   <= s1_abort_next;
      s2_op_reg      <= s1_op_reg;
      s2_addr_reg    <= s1_addr_reg;
      s2_abort_reg   <= s1_abort_reg;
    end
  end

  // Write data arrive on the second edge; each low lane select enables its lane.
  assign wr_mask      = s2_abort_reg ? '0 : ~byte_lane_select_n; // R8 R9 R14 R15
  assign buf_in_valid = qual && (s2_op_reg == PSBC_OP_WRITE) && (wr_mask != '0); // R18
  assign push         = buf_in_valid && buf_in_ready;

  // Lane packing: each lane holds its parity bit above its byte.
  for (genvar g = 0; g < LANES; g++)
  begin : g_lane
    assign wr_word[g*PSBC_LANE_W +: PSBC_LANE_W] = {parity_lane_in[g], dq_in[g*PSBC_BYTE_W +: PSBC_BYTE_W]};
    assign rd_bytes[g*PSBC_BYTE_W +: PSBC_BYTE_W] = mem_rdata[g*PSBC_LANE_W +: PSBC_BYTE_W];
    assign rd_parity[g] = mem_rdata[g*PSBC_LANE_W + PSBC_BYTE_W];
  end

  // Held writes drain while awake; sleep stalls the drain and keeps the contents.
  assign mem_wr_en = buf_out_valid && !sleep_active;
  assign mem_rd_en = qual && (s1_op_reg == PSBC_OP_READ); // R2 R3 R4

  psbc_buf #(
    .WIDTH (BUF_W),
    .DEPTH (PSBC_BUF_DEPTH)
  ) u_wbuf (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   ({s2_addr_reg, wr_mask, wr_word}),
    .out_valid (buf_out_valid),
    .out_ready (!sleep_active),
    .out_data  (buf_out_data)
  );

  psbc_mem #(
    .ADDR_W (ADDR_W),
    .LANES  (LANES),
    .LANE_W (PSBC_LANE_W)
  ) u_mem (
    .ref_clk  (ref_clk),
    .wr_en    (mem_wr_en),
    .wr_addr  (buf_out_data[BUF_W-1 -: ADDR_W]),
    .wr_lanes (buf_out_data[WORD_W +: LANES]),
    .wr_data  (buf_out_data[WORD_W-1:0]),
    .rd_en    (mem_rd_en),
    .rd_addr  (s1_addr_reg),
    .rd_data  (mem_rdata)
  );

  // Read output stage, loaded on the second qualified edge after the address.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_valid_reg   <= 1'b0; // R12
      dq_out_reg     <= '0;
      parity_out_reg <= '0;
    end
    else if (sleep_active)
    begin
      rd_valid_reg <= 1'b0; // R16
    end
    else if (qual)
    begin
      rd_valid_reg <= (s2_op_reg == PSBC_OP_READ); // R11 R19
      if (s2_op_reg == PSBC_OP_READ)
      begin
        dq_out_reg     <= rd_bytes;
        parity_out_reg <= rd_parity;
      end
    end
  end

  // The output enable gates the drivers directly, without the clock.
  assign dq_out          = dq_out_reg;
  assign parity_lane_out = parity_out_reg;
  assign dq_oe           = rd_valid_reg && !output_enable_n && !sleep_active; // R4 R5 R13
  assign parity_lane_oe  = rd_valid_reg && !output_enable_n && !sleep_active; // R13

  // Two qualified edges in a row.
  sequence s_two_qual;
    qual ##1 qual;
  endsequence

  // A deselect command leaves the bus floating two edges later.
  property p_deselect_float;
    (cmd_load && !all_sel) ##1 s_two_qual |=> !dq_oe;
  endproperty
  a_deselect_float: assert property (p_deselect_float) else $error("deselect drove the bus"); // R1

  // A read begun and followed by two qualified edges presents valid data.
  property p_read_latency;
    begin_read ##1 s_two_qual |=> rd_valid_reg && (dq_oe == (!output_enable_n && !sleep_active));
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read data late or missing"); // R2 R19

  // A continuation steps the burst counter by one and wraps.
  property p_burst_step;
    adv_cont |=> burst_cnt_reg == 2'($past(burst_cnt_reg) + 2'h1);
  endproperty
  a_burst_step: assert property (p_burst_step) else $error("burst counter did not advance"); // R3 R17

  // An inactive output enable keeps the bus floating.
  property p_oe_mask;
    output_enable_n |-> !dq_oe && !parity_lane_oe;
  endproperty
  a_oe_mask: assert property (p_oe_mask) else $error("bus driven with output enable off"); // R4 R5 R13

  // A write leaves the bus floating at its data edge.
  property p_write_float;
    begin_write ##1 s_two_qual |=> !rd_valid_reg && !dq_oe;
  endproperty
  a_write_float: assert property (p_write_float) else $error("bus driven during write data"); // R11

  // An aborted write never reaches the memory.
  property p_abort_no_push;
    (begin_write && lanes_off) ##1 qual ##1 qual |-> !buf_in_valid;
  endproperty
  a_abort_no_push: assert property (p_abort_no_push) else $error("aborted write stored data"); // R8

  // A stalled edge holds the address and the output data.
  property p_stall_hold;
    (clock_qualifier_n && !sleep_active) |=> $stable(s1_addr_reg) && $stable(dq_out_reg) && $stable(rd_valid_reg);
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("state moved on a stalled edge"); // R10

  // Two cycles of sleep request put the device to sleep and float the bus.
  property p_sleep_entry;
    sleep_request [*2] |=> sleep_active && !dq_oe;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry not in two cycles"); // R16

  // Stored lanes follow the low lane selects at the data edge.
  property p_lane_mask;
    push ##1 !sleep_active |-> mem_wr_en && (buf_out_data[WORD_W +: LANES] == $past(~byte_lane_select_n));
  endproperty
  a_lane_mask: assert property (p_lane_mask) else $error("wrong lanes written"); // R14

  // A selected load with a high write strobe always starts a read.
  property p_read_wins;
    (cmd_load && all_sel && write_enable_n) |=> s1_op_reg == PSBC_OP_READ;
  endproperty
  a_read_wins: assert property (p_read_wins) else $error("high write strobe not a read"); // R15

  // A continuation keeps the address bits above the burst counter.
  property p_upper_hold;
    adv_cont |=> s1_addr_reg[ADDR_W-1:PSBC_BURST_W] == $past(s1_addr_reg[ADDR_W-1:PSBC_BURST_W]);
  endproperty
  a_upper_hold: assert property (p_upper_hold) else $error("burst left its address block"); // R17

  // Two cycles without a sleep request wake the device.
  property p_sleep_exit;
    (!sleep_request) [*2] |=> !sleep_active;
  endproperty
  a_sleep_exit: assert property (p_sleep_exit) else $error("sleep exit not in two cycles"); // R16

  // A write with some lane selected at its data edge pushes its word.
  property p_write_push;
    (begin_write && !lanes_off) ##1 qual ##1 (qual && !lanes_off) |-> push;
  endproperty
  a_write_push: assert property (p_write_push) else $error("write data not taken"); // R6 R14

endmodule
`default_nettype wire

// ===== sim/psbc_host.sv
`timescale 1ns/1ns
`default_nettype none
module psbc_host
  import psbc_pkg::*;
(
  // Clock.
  input  wire logic                              ref_clk,
  // Command pins.
  output var  logic [PSBC_ADDR_W-1:0]            address,
  output var  logic                              chip_select_1_n,
  output var  logic                              chip_select_2,
  output var  logic                              chip_select_3_n,
  output var  logic                              advance_or_load,
  output var  logic                              write_enable_n,
  output var  logic [PSBC_LANES-1:0]             byte_lane_select_n,
  output var  logic                              clock_qualifier_n,
  output var  logic                              burst_order,
  // Asynchronous pins.
  output var  logic                              output_enable_n,
  output var  logic                              sleep_request,
  // Write data and parity.
  output var  logic [PSBC_LANES*PSBC_BYTE_W-1:0] dq_in,
  output var  logic [PSBC_LANES-1:0]             parity_lane_in
);
  logic [35:0] q1 = '0;
  logic [35:0] q2 = '0;
  logic [3:0]  l1 = 4'hf;
  logic [3:0]  l2 = 4'hf;
  logic        v1 = 1'b0;
  logic        v2 = 1'b0;
  int          wake_cnt = 0;

  initial
  begin
    {address, chip_select_1_n, chip_select_2, chip_select_3_n} = {19'h0, 3'h6};
    {advance_or_load, write_enable_n, byte_lane_select_n, clock_qualifier_n} = {2'h1, 4'hf, 1'b0};
    {burst_order, output_enable_n, sleep_request} = 3'h0;
    {parity_lane_in, dq_in} = '0;
  end

  // Drives one edge; write data follows its command two qualified edges later.
  task automatic step(input logic stall, adv, sel, we_n, mode, input logic [18:0] addr,
                      input logic [3:0] cl, dl, input logic [35:0] wd, input logic wr);
    logic ign;
    logic off;
    ign = adv || stall;
    off = sleep_request || (wake_cnt > 0);
    @(negedge ref_clk);
    clock_qualifier_n = stall;
    advance_or_load   = adv;
    burst_order       = mode;
    {chip_select_1_n, chip_select_2, chip_select_3_n} = off ? {1'b1, 2'($urandom)} :
      ign ? 3'($urandom) : sel ? 3'h2 : {1'b1, 2'($urandom)};
    write_enable_n          = ign ? 1'($urandom) : we_n;
    address                 = ign ? 19'($urandom) : addr;
    byte_lane_select_n      = v2 ? l2 : cl;
    {parity_lane_in, dq_in} = v2 ? q2 : 36'({$urandom(), $urandom()});
    @(posedge ref_clk);
    if (wake_cnt > 0)
      wake_cnt--;
    if (!stall)
    begin
      {v2, q2, l2} = {v1, q1, l1};
      {v1, q1, l1} = {wr, wd, dl};
    end
  endtask

  // Sets the asynchronous pins and keeps the selects off after waking.
  task automatic set_pin(input logic oe_n, slp);
    if (sleep_request && !slp)
      wake_cnt = 2;
    output_enable_n = oe_n;
    sleep_request   = slp;
  endtask
endmodule
`default_nettype wire

// ===== sim/psbc_sram_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHECK(got, exp, msg) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("mismatch at %0t: %s", $time, msg); \
    end \
  end
module psbc_sram_test
  import psbc_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic [18:0] address;
  logic        chip_select_1_n, chip_select_2, chip_select_3_n;
  logic        advance_or_load, write_enable_n, clock_qualifier_n, burst_order;
  logic        output_enable_n, sleep_request, dq_oe, parity_lane_oe;
  logic [3:0]  byte_lane_select_n, parity_lane_in, parity_lane_out;
  logic [31:0] dq_in, dq_out;
  logic [35:0] mem [int];
  logic [35:0] e_d [2];
  logic [18:0] e_a [2] = '{19'h0, 19'h0};
  logic [18:0] b_start;
  logic [3:0]  e_l [2];
  int          e_k [2] = '{0, 0};
  int          b_kind = 0;
  int          b_step = 0;
  int          error_cnt = 0;
  int          num_checks = 0;
  logic        mode = 1'b0;
  logic        oe_n = 1'b0;
  logic [35:0] held;

  always #5 ref_clk = ~ref_clk;

  psbc_host psbc_host_i (.ref_clk(ref_clk), .address(address), .chip_select_1_n(chip_select_1_n),
    .chip_select_2(chip_select_2), .chip_select_3_n(chip_select_3_n), .advance_or_load(advance_or_load),
    .write_enable_n(write_enable_n), .byte_lane_select_n(byte_lane_select_n),
    .clock_qualifier_n(clock_qualifier_n), .burst_order(burst_order), .output_enable_n(output_enable_n),
    .sleep_request(sleep_request), .dq_in(dq_in), .parity_lane_in(parity_lane_in));

  psbc_sram psbc_sram_i (.ref_clk(ref_clk), .rst_n(rst_n), .address(address),
    .chip_select_1_n(chip_select_1_n), .chip_select_2(chip_select_2), .chip_select_3_n(chip_select_3_n),
    .advance_or_load(advance_or_load), .write_enable_n(write_enable_n),
    .byte_lane_select_n(byte_lane_select_n), .clock_qualifier_n(clock_qualifier_n),
    .burst_order(burst_order), .output_enable_n(output_enable_n), .sleep_request(sleep_request),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .parity_lane_in(parity_lane_in),
    .parity_lane_out(parity_lane_out), .parity_lane_oe(parity_lane_oe));

  function automatic logic [1:0] nxt(input logic m, input logic [1:0] s, input int n);
    return m ? (s ^ 2'(n)) : 2'(s + 2'(n));
  endfunction

  task automatic pins(input logic oe, slp);
    @(negedge ref_clk);
    oe_n = oe;
    psbc_host_i.set_pin(oe, slp);
  endtask

  // Issues one command and checks the access that is due at this edge.
  task automatic op(input logic adv, sel, we_n, input logic [18:0] addr, input logic [3:0] cl, dl);
    logic [35:0] wd;
    logic [35:0] want;
    wd = 36'({$urandom(), $urandom()});
    if (!adv)
    begin
      b_kind  = !sel ? 0 : we_n ? 1 : (&cl ? 0 : 2);
      b_start = addr;
      b_step  = 0;
    end
    else
      b_step++;
    psbc_host_i.step(1'b0, adv, sel, we_n, mode, addr, cl, dl, wd, b_kind == 2);
    #1;
    want = mem.exists(e_a[1]) ? mem[e_a[1]] : 'x;
    if (e_k[1] == 1)
    begin
      `CHECK({parity_lane_out, dq_out}, want, "read data")
      `CHECK(dq_oe, !oe_n, "read drive")
    end
    else
      `CHECK(dq_oe, 1'b0, "bus floats")
    `CHECK(parity_lane_oe, (e_k[1] == 1) && !oe_n, "parity drive")
    if (e_k[1] == 2)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (!e_l[1][i])
          {want[32+i], want[8*i +: 8]} = {e_d[1][32+i], e_d[1][8*i +: 8]};
      end
      mem[e_a[1]] = want;
    end
    {e_k[1], e_a[1], e_d[1], e_l[1]} = {e_k[0], e_a[0], e_d[0], e_l[0]};
    {e_k[0], e_a[0], e_d[0], e_l[0]} = {b_kind, {b_start[18:2], nxt(mode, b_start[1:0], b_step)}, wd, dl};
  endtask

  task automatic flush(input int n, input logic [3:0] l);
    for (int i = 0; i < n; i++)
      op(1'(i % 2), 1'b0, 1'b1, 19'h0, l, l);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #100000;
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    results();
  end

  initial
  begin
    void'($urandom(32'h3c27));
    repeat (6) @(posedge ref_clk);
    #1;
    `CHECK(dq_oe, 1'b0, "floats in reset")
    @(negedge ref_clk);
    rst_n = 1'b1;
    flush(2, 4'hf);
    $display("test reset done");
    for (int n = 0; n < 8; n++)
    begin
      mode = 1'($urandom);
      for (int j = 0; j < 4; j++)
        op(j != 0, 1'b1, 1'b0, {17'(n % 2), 2'($urandom)}, 4'($urandom) & 4'h7, n < 2 ? 4'h0 : 4'($urandom));
      flush(4, 4'hf);
      pins(n == 3 ? 1'b0 : 1'($urandom), 1'b0);
      for (int j = 0; j < 4; j++)
        op(j != 0, 1'b1, 1'b1, {17'(n % 2), 2'($urandom)}, 4'($urandom), 4'hf);
      if (n == 3)
      begin
        held = mem[{b_start[18:2], nxt(mode, b_start[1:0], 1)}];
        repeat (3) psbc_host_i.step(1'b1, 1'($urandom), 1'b1, 1'b0, mode, 19'($urandom), 4'h0, 4'h0, '0, 1'b0);
        #1;
        `CHECK({parity_lane_out, dq_out, dq_oe}, {held, 1'b1}, "stall holds")
      end
      flush(2, 4'hf);
    end
    $display("test bursts done");
    op(1'b0, 1'b1, 1'b0, 19'h4, 4'hf, 4'h0);
    flush(4, 4'h0);
    pins(1'b1, 1'b0);
    op(1'b0, 1'b1, 1'b1, 19'h4, 4'h0, 4'hf);
    flush(2, 4'hf);
    pins(1'b0, 1'b0);
    #1;
    `CHECK(dq_oe, 1'b1, "output enable acts at once")
    flush(2, 4'hf);
    $display("test abort done");
    pins(1'b0, 1'b1);
    repeat (5)
    begin
      psbc_host_i.step(1'b0, 1'b0, 1'b1, 1'b1, mode, 19'h5, 4'hf, 4'hf, '0, 1'b0);
      #1;
      `CHECK(dq_oe, 1'b0, "asleep floats")
    end
    pins(1'b0, 1'b0);
    flush(2, 4'hf);
    op(1'b0, 1'b1, 1'b1, 19'h5, 4'h0, 4'hf);
    flush(2, 4'hf);
    $display("test sleep done");
    results();
  end
endmodule
`default_nettype wire
